/* File: shared/dic_pkg.sv */
// Package with register map, field layout and timing constants of the input conditioner.
package dic_pkg;
   localparam int NUM_CH = 3;
   localparam int CLK_HZ = 100_000_000;
   localparam int SCAN_MS = 5;
   localparam int SCAN_CYCLES = CLK_HZ / 1000 * SCAN_MS;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int AC_EXT_MS = 30;
   localparam int DELAY_W = 21;
   localparam int MAX_DELAY_MS = 1_800_000;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ACT0 = 8'h10;
   localparam logic [7:0] ADDR_DROP0 = 8'h20;
   localparam int CTRL_POL_LSB = 0;
   localparam int CTRL_AC_LSB = 8;
   localparam int STAT_RAW_LSB = 0;
   localparam int STAT_COND_LSB = 8;
   localparam int STAT_INT_LSB = 16;
   localparam int STAT_OUT_LSB = 24;
   localparam logic [NUM_CH-1:0] POL_RESET = '0;
   localparam logic [NUM_CH-1:0] AC_RESET = '0;
   localparam logic [DELAY_W-1:0] DELAY_RESET = '0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dic_pkg

/* File: hdl/dic_chan.sv */
// One input channel: polarity, pick-up and drop-off delay qualification on the scan tick.
`timescale 1ns/1ns
`default_nettype none
module dic_chan (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scan_tick,
   input wire logic raw,
   input wire logic invert,
   input wire logic ac_mode,
   input wire logic [dic_pkg::DELAY_W-1:0] act_ms,
   input wire logic [dic_pkg::DELAY_W-1:0] drop_ms,
   output logic cond
);
   typedef struct packed {
      logic cond;
      logic [dic_pkg::DELAY_W+2:0] elapsed;
   } dic_chan_state_t;

   dic_chan_state_t s;
   dic_chan_state_t next_s;
   logic level;
   logic [dic_pkg::DELAY_W+2:0] need;

   // Elapsed time counts in milliseconds, five per scan, so delays take effect in whole 5 ms scan steps.
   always_comb begin
      level = raw ^ invert;
      need = s.cond ? ({3'b000, drop_ms} + (ac_mode ? (dic_pkg::DELAY_W+3)'(dic_pkg::AC_EXT_MS) : '0)) // R5 R6
                    : {3'b000, act_ms}; // R4
      next_s = s;
      if (scan_tick) begin
         if (level == s.cond) begin
            next_s.elapsed = '0; // R9
         end else if (s.elapsed + (dic_pkg::DELAY_W+3)'(dic_pkg::SCAN_MS) > need) begin
            next_s.cond = level; // R9
            next_s.elapsed = '0;
         end else begin
            next_s.elapsed = s.elapsed + (dic_pkg::DELAY_W+3)'(dic_pkg::SCAN_MS);
         end
      end
   end

   // State register; the conditioned level resets low.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cond = s.cond;

   stable_change_a: assert property (@(posedge clk) disable iff (!nrst)
      (s.cond != $past(s.cond)) |-> $past(scan_tick)) // R9
      else $error("Conditioned state changed outside a scan tick.");
   zero_delay_a: assert property (@(posedge clk) disable iff (!nrst)
      (scan_tick && !s.cond && level && act_ms == '0) |=> s.cond) // R4
      else $error("Zero activation delay did not act on the tick.");
endmodule : dic_chan
`default_nettype wire

/* File: hdl/dic_top.sv */
// Digital input conditioner top: scan divider, pin sync, channels, staged outputs, AXI4-Lite registers.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1: Sample every input once per 5 ms.
// R2: Input change visible within one scan.
// R3: Per-input polarity, energized reads 1 default.
// R4: Activation delay postpones 0 to 1.
// R5: Drop-off delay postpones 1 to 0.
// R6: AC mode adds 30 ms deactivation.
// R7: Internal logic acts one scan later.
// R8: Relay contact updated one further scan.
// R9: Delay needs continuous stable level, else restart.
module dic_top #(parameter int SCAN_DIV = dic_pkg::SCAN_CYCLES) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [dic_pkg::NUM_CH-1:0] binary_input_channel,
   output logic [dic_pkg::NUM_CH-1:0] internal_input,
   output logic [dic_pkg::NUM_CH-1:0] relay_contact_channel,
   output logic scan_strobe,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int N = dic_pkg::NUM_CH;
   localparam int DW = dic_pkg::DELAY_W;

   typedef struct packed {
      logic [N-1:0] sync1;
      logic [N-1:0] sync2;
      logic [N-1:0] sampled;
      logic [N-1:0] internal;
      logic [N-1:0] relay;
      logic [18:0] div;
      logic tick;
      logic [N-1:0] invert;
      logic [N-1:0] ac;
      logic [N-1:0][DW-1:0] act;
      logic [N-1:0][DW-1:0] drop;
      logic aw_held;
      logic [7:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } dic_top_state_t;

   dic_top_state_t s;
   dic_top_state_t next_s;
   logic [N-1:0] cond;

   // Byte-lane merge used by every writable register.
   function automatic logic [31:0] dic_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return r;
   endfunction : dic_merge

   // Channel index of a delay register, or -1 when the offset is not one.
   function automatic int dic_delay_idx(input logic [7:0] addr, input logic [7:0] base);
      int r;
      r = -1;
      for (int i = 0; i < N; i++) begin
         if (addr == base + 8'(4 * i)) begin
            r = i;
         end
      end
      return r;
   endfunction : dic_delay_idx

   // One qualifier per input; the conditioned level only moves on the scan tick.
   for (genvar g = 0; g < N; g++) begin : gen_ch
      dic_chan u_chan (
         .clk(clk),
         .nrst(nrst),
         .scan_tick(s.tick),
         .raw(s.sampled[g]),
         .invert(s.invert[g]),
         .ac_mode(s.ac[g]),
         .act_ms(s.act[g]),
         .drop_ms(s.drop[g]),
         .cond(cond[g])
      );
   end

   // Next-state logic: scan divider, pipeline stages and register bus.
   always_comb begin
      int wi;
      int ri;
      logic [31:0] merged;
      logic [31:0] cur;
      wi = -1;
      ri = -1;
      merged = '0;
      cur = '0;
      next_s = s;
      // Pins are asynchronous to clk, so two flops sit before any use.
      next_s.sync1 = binary_input_channel;
      next_s.sync2 = s.sync1;
      next_s.tick = 1'b0;
      // SCAN_DIV is 5 ms of clk by default; delays count in scans, so a shorter divider only speeds time up.
      if (s.div == 19'(SCAN_DIV - 1)) begin
         next_s.div = '0;
         next_s.tick = 1'b1; // R1
         next_s.sampled = s.sync2; // R1 R2
      end else begin
         next_s.div = s.div + 19'h00001;
      end
      // Each stage lags the previous by one scan, so downstream latency stays bounded.
      if (s.tick) begin
         next_s.internal = cond; // R7
         next_s.relay = s.internal; // R8
      end

      // Write path: address and data accepted in either order.
      if (s_axi_awvalid && !s.aw_held) begin
         next_s.aw_held = 1'b1;
         next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_held) begin
         next_s.w_held = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = dic_pkg::RESP_OKAY;
         if (s.awaddr == dic_pkg::ADDR_CTRL) begin
            cur = '0;
            cur[dic_pkg::CTRL_POL_LSB +: N] = s.invert;
            cur[dic_pkg::CTRL_AC_LSB +: N] = s.ac;
            merged = dic_merge(cur, s.wdata, s.wstrb);
            next_s.invert = merged[dic_pkg::CTRL_POL_LSB +: N]; // R3
            next_s.ac = merged[dic_pkg::CTRL_AC_LSB +: N]; // R6
         end else if (dic_delay_idx(s.awaddr, dic_pkg::ADDR_ACT0) >= 0) begin
            wi = dic_delay_idx(s.awaddr, dic_pkg::ADDR_ACT0);
            merged = dic_merge({11'h000, s.act[wi]}, s.wdata, s.wstrb);
            next_s.act[wi] = (merged > dic_pkg::MAX_DELAY_MS) ? DW'(dic_pkg::MAX_DELAY_MS) : merged[DW-1:0]; // R4
         end else if (dic_delay_idx(s.awaddr, dic_pkg::ADDR_DROP0) >= 0) begin
            wi = dic_delay_idx(s.awaddr, dic_pkg::ADDR_DROP0);
            merged = dic_merge({11'h000, s.drop[wi]}, s.wdata, s.wstrb);
            next_s.drop[wi] = (merged > dic_pkg::MAX_DELAY_MS) ? DW'(dic_pkg::MAX_DELAY_MS) : merged[DW-1:0]; // R5
         end else if (s.awaddr != dic_pkg::ADDR_STATUS) begin
            next_s.bresp = dic_pkg::RESP_SLVERR;
         end
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // Read path: one-cycle accept, data registered.
      if (s_axi_arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = dic_pkg::RESP_OKAY;
         next_s.rdata = '0;
         if (s_axi_araddr == dic_pkg::ADDR_CTRL) begin
            next_s.rdata[dic_pkg::CTRL_POL_LSB +: N] = s.invert;
            next_s.rdata[dic_pkg::CTRL_AC_LSB +: N] = s.ac;
         end else if (s_axi_araddr == dic_pkg::ADDR_STATUS) begin
            next_s.rdata[dic_pkg::STAT_RAW_LSB +: N] = s.sampled;
            next_s.rdata[dic_pkg::STAT_COND_LSB +: N] = cond;
            next_s.rdata[dic_pkg::STAT_INT_LSB +: N] = s.internal;
            next_s.rdata[dic_pkg::STAT_OUT_LSB +: N] = s.relay;
         end else if (dic_delay_idx(s_axi_araddr, dic_pkg::ADDR_ACT0) >= 0) begin
            ri = dic_delay_idx(s_axi_araddr, dic_pkg::ADDR_ACT0);
            next_s.rdata = {11'h000, s.act[ri]};
         end else if (dic_delay_idx(s_axi_araddr, dic_pkg::ADDR_DROP0) >= 0) begin
            ri = dic_delay_idx(s_axi_araddr, dic_pkg::ADDR_DROP0);
            next_s.rdata = {11'h000, s.drop[ri]};
         end else begin
            next_s.rresp = dic_pkg::RESP_SLVERR;
         end
      end else if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      // Ready flags live in their own flops so every bus output leaves straight from a register.
      next_s.aw_rdy = !next_s.aw_held;
      next_s.w_rdy = !next_s.w_held;
      next_s.ar_rdy = !next_s.rvalid;
   end

   // State register; settings reset to the documented defaults.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.invert <= dic_pkg::POL_RESET; // R3
         s.ac <= dic_pkg::AC_RESET; // R6
         s.aw_rdy <= 1'b1;
         s.w_rdy <= 1'b1;
         s.ar_rdy <= 1'b1;
         for (int i = 0; i < N; i++) begin
            s.act[i] <= dic_pkg::DELAY_RESET;
            s.drop[i] <= dic_pkg::DELAY_RESET;
         end
      end else begin
         s <= next_s;
      end
   end

   assign internal_input = s.internal;
   assign relay_contact_channel = s.relay;
   assign scan_strobe = s.tick;
   assign s_axi_awready = s.aw_rdy;
   assign s_axi_wready = s.w_rdy;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.ar_rdy;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;

   sequence tick_seen;
      s.tick;
   endsequence
   tick_period_a: assert property (@(posedge clk) disable iff (!nrst)
      tick_seen |=> !s.tick [*8]) // R1
      else $error("Scan tick repeated too soon.");
   sample_cap_a: assert property (@(posedge clk) disable iff (!nrst)
      tick_seen |-> s.sampled == $past(s.sync2)) // R2
      else $error("Sample did not take the synchronised pins.");
   sample_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      !s.tick |-> $stable(s.sampled)) // R1
      else $error("Sample changed between ticks.");
   internal_stage_a: assert property (@(posedge clk) disable iff (!nrst)
      tick_seen |=> s.internal == $past(cond)) // R7
      else $error("Internal stage missed the conditioned state.");
   relay_stage_a: assert property (@(posedge clk) disable iff (!nrst)
      tick_seen |=> s.relay == $past(s.internal)) // R8
      else $error("Relay stage did not lag one scan.");
   relay_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      !$past(s.tick) |-> $stable(s.relay)) // R8
      else $error("Relay output changed off the scan.");
endmodule : dic_top
`default_nettype wire

/* File: testbench/dic_field.sv */
// Model of the field contacts that energize the isolated input terminals.
`timescale 1ns/1ns
`default_nettype none
module dic_field (
   input wire logic clk,
   input wire logic [dic_pkg::NUM_CH-1:0] want,
   output logic [dic_pkg::NUM_CH-1:0] terminal
);
   // A contact settles one clock after it is commanded and then holds its level, as a wired contact does.
   always_ff @(posedge clk) begin
      terminal <= want;
   end
endmodule : dic_field
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking testbench of the input conditioner.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
   // The scan is shortened so the run stays short; delays still count in milliseconds per scan.
   localparam int SIM_SCAN = 200;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [dic_pkg::NUM_CH-1:0] want = '0;
   logic [dic_pkg::NUM_CH-1:0] terminal, internal_input, relay_contact_channel, prev = '0;
   logic scan_strobe, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = '0;
   logic [7:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic [31:0] rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   int fail_count = 0, n_checks = 0, cyc = 0, last = 0;

   // Clock and a free-running cycle count used to time the scan ticks.
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   dic_field field (.clk(clk), .want(want), .terminal(terminal));
   dic_top #(.SCAN_DIV(SIM_SCAN)) uut (.clk(clk), .nrst(nrst), .binary_input_channel(terminal),
      .internal_input(internal_input),
      .relay_contact_channel(relay_contact_channel), .scan_strobe(scan_strobe), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // Write one word; address and data are offered together and each is released once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      `CHK("write answer", 1'b1, bvalid)
      rs = bresp;
      bready <= 1'b0;
      // One idle edge keeps a following call from driving bready twice in one step.
      @(posedge clk);
   endtask : wr

   // Read one word; rready stays high until the answer is sampled.
   task automatic rdw(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      `CHK("read answer", 1'b1, rvalid)
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rdw

   // Wait for the next scan tick, let its updates land, then check the period and the relay stage.
   task automatic tick();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (scan_strobe !== 1'b1 && n < 2 * SIM_SCAN);
      `CHK("scan strobe", 1'b1, scan_strobe)
      if (last != 0) `CHK("scan period", SIM_SCAN, cyc - last)
      last = cyc;
      repeat (3) @(posedge clk);
      `CHK("relay stage", prev, relay_contact_channel)
      prev = internal_input;
   endtask : tick

   // Settings come up with no inversion, AC off and zero delays; an unmapped place is refused.
   task automatic t_defaults();
      rdw(dic_pkg::ADDR_CTRL);
      `CHK("ctrl reset", 32'h0, rd)
      for (int i = 0; i < dic_pkg::NUM_CH; i++) begin
         rdw(dic_pkg::ADDR_ACT0 + 8'(4 * i));
         `CHK("act reset", 32'h0, rd)
         rdw(dic_pkg::ADDR_DROP0 + 8'(4 * i));
         `CHK("drop reset", 32'h0, rd)
      end
      rdw(8'h40);
      `CHK("unmapped resp", dic_pkg::RESP_SLVERR, rs)
      wr(8'h40, 32'h0);
      `CHK("unmapped wr resp", dic_pkg::RESP_SLVERR, rs)
      wr(dic_pkg::ADDR_STATUS, 32'hffffffff);
      `CHK("status wr resp", dic_pkg::RESP_OKAY, rs)
      // Only the low byte lane lands, and an oversized delay is clamped to the top of its range.
      wstrb <= 4'h1;
      wr(dic_pkg::ADDR_ACT0, 32'h00000105);
      wstrb <= 4'hf;
      rdw(dic_pkg::ADDR_ACT0);
      `CHK("act byte lane", 32'h5, rd)
      wr(dic_pkg::ADDR_DROP0, 32'hffffffff);
      rdw(dic_pkg::ADDR_DROP0);
      `CHK("drop clamp", 32'(dic_pkg::MAX_DELAY_MS), rd)
      wr(dic_pkg::ADDR_ACT0, 32'h0);
      wr(dic_pkg::ADDR_DROP0, 32'h0);
   endtask : t_defaults

   // An energized input is sampled within one scan and reaches internal logic one scan later.
   task automatic t_pickup();
      tick();
      want <= 3'h1;
      tick();
      rdw(dic_pkg::ADDR_STATUS);
      `CHK("raw sample", 3'h1, rd[2:0])
      tick();
      `CHK("internal ch0", 1'b1, internal_input[0])
   endtask : t_pickup

   // An inverted channel reads a de-energized terminal as 1.
   task automatic t_invert();
      wr(dic_pkg::ADDR_CTRL, 32'h2);
      tick();
      tick();
      `CHK("inverted ch1", 3'h3, internal_input)
   endtask : t_invert

   // A 12 ms activation delay holds the rising edge back by at least two scans.
   task automatic t_pickdelay();
      wr(dic_pkg::ADDR_ACT0 + 8'h08, 32'hc);
      tick();
      want <= 3'h5;
      repeat (3) tick();
      `CHK("act early ch2", 1'b0, internal_input[2])
      repeat (2) tick();
      `CHK("act late ch2", 1'b1, internal_input[2])
   endtask : t_pickdelay

   // Drop-off delay on ch2 and the 30 ms AC extension on ch0 both hold the falling edge back.
   task automatic t_dropoff();
      wr(dic_pkg::ADDR_DROP0 + 8'h08, 32'hc);
      wr(dic_pkg::ADDR_CTRL, 32'h102);
      tick();
      want <= 3'h0;
      repeat (3) tick();
      `CHK("drop early", 3'h7, internal_input)
      repeat (2) tick();
      `CHK("drop late", 3'h3, internal_input)
      repeat (2) tick();
      `CHK("ac still held", 3'h3, internal_input)
      repeat (2) tick();
      `CHK("ac late", 3'h2, internal_input)
   endtask : t_dropoff

   // Prints the verdict and ends the run.
   task automatic close_out();
      if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // Main sequence: reset for ten cycles, then the scenarios in order.
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_defaults();
      t_pickup();
      t_invert();
      t_pickdelay();
      t_dropoff();
      close_out();
   end

   // Watchdog sized for about a hundred shortened scans, several times what the scenarios need.
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
endmodule : tb
`default_nettype wire
